// ===== src/acr_pkg.sv
// Shared constants and timing helpers for the conversion and readout block
package acr_pkg;

   // ---------------------------------------------------------------
   // Clock and widths
   // ---------------------------------------------------------------
   localparam int CLK_NS = 8;
   localparam int RES_W = 16;

   // ---------------------------------------------------------------
   // Conversion timing
   // ---------------------------------------------------------------
   localparam int CONV_NS = 1200;
   localparam int CONV_CYC = CONV_NS / CLK_NS;
   localparam int DATA_TO_BUSY_NS = 12;
   localparam int DATA_TO_BUSY_CYC = (DATA_TO_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_RDC_NS = 525;
   localparam int SYNC_RDC_CYC = SYNC_RDC_NS / CLK_NS;
   localparam int SYNC_TO_BUSY_NS = 25;
   localparam int SYNC_TO_BUSY_CYC = (SYNC_TO_BUSY_NS + CLK_NS - 1) / CLK_NS;

   // ---------------------------------------------------------------
   // Serial master timing, per divider setting
   // ---------------------------------------------------------------
   localparam int LEAD0_NS = 3;
   localparam int LEADN_NS = 17;
   localparam int TAIL0_NS = 3;
   localparam int TAIL1_NS = 55;
   localparam int TAIL2_NS = 130;
   localparam int TAIL3_NS = 290;
   localparam int PER0_NS = 32;
   localparam int PER1_NS = 64;
   localparam int PER2_NS = 128;
   localparam int PER3_NS = 256;
   localparam logic [1:0] DIV_NONE = 2'h0;
   localparam logic [4:0] BIT_LAST = 5'h0f;

   // Half period of the serial clock in system cycles
   function automatic logic [4:0] sclk_half(input logic [1:0] div);
      int ns;
      unique case (div)
         2'h0: ns = PER0_NS;
         2'h1: ns = PER1_NS;
         2'h2: ns = PER2_NS;
         default: ns = PER3_NS;
      endcase
      return 5'(ns / (2 * CLK_NS));
   endfunction

   // Frame lead before the first serial clock edge, rounded up
   function automatic logic [5:0] lead_cyc(input logic [1:0] div);
      int ns;
      ns = (div == DIV_NONE) ? LEAD0_NS : LEADN_NS;
      return 6'((ns + CLK_NS - 1) / CLK_NS);
   endfunction

   // Frame hold after the last serial clock edge, rounded up
   function automatic logic [5:0] tail_cyc(input logic [1:0] div);
      int ns;
      unique case (div)
         2'h0: ns = TAIL0_NS;
         2'h1: ns = TAIL1_NS;
         2'h2: ns = TAIL2_NS;
         default: ns = TAIL3_NS;
      endcase
      return 6'((ns + CLK_NS - 1) / CLK_NS);
   endfunction

endpackage

// ===== src/acr_sclk_div.sv
// Internal serial clock generator with programmable half period
`timescale 1ns/10ps
module acr_sclk_div (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic run_in,
   input wire logic [4:0] half_in,
   output logic sclk_out,
   output logic fall_out
);
   import acr_pkg::*;

   typedef struct packed {
      logic [4:0] cnt;
      logic sclk;
      logic fall;
   } acr_div_t;

   acr_div_t q;
   acr_div_t d;

   // Clock idles low, toggles every half period while running
   always_comb begin
      d = q;
      d.fall = 1'b0;
      if (!run_in) begin
         d.cnt = 5'h00;
         d.sclk = 1'b0;
      end else if (q.cnt == half_in - 5'h01) begin
         d.cnt = 5'h00;
         d.sclk = ~q.sclk;
         d.fall = q.sclk; // Falling edge marks the end of a bit
      end else begin
         d.cnt = q.cnt + 5'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sclk_out = q.sclk;
   assign fall_out = q.fall;
endmodule // acr_sclk_div

// ===== src/acr_top.sv
// Conversion handshake and parallel/serial result readout
`timescale 1ns/10ps
module acr_top (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic convert_start_n_in,
   input wire logic [acr_pkg::RES_W-1:0] conv_result_in,
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   input wire logic serial_parallel_select_in,
   input wire logic clock_source_select_in,
   input wire logic read_during_convert_select_in,
   input wire logic frame_polarity_select_in,
   input wire logic [1:0] clock_divide_select_in,
   input wire logic ext_sclk_in,
   output logic busy_out,
   output logic [acr_pkg::RES_W-1:0] data_out,
   output logic data_oe_n_out,
   output logic sclk_out,
   output logic sclk_oe_n_out,
   output logic sync_out,
   output logic sync_oe_n_out,
   output logic serial_data_out,
   output logic serial_data_oe_n_out
);
   import acr_pkg::*;

   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CST_IDLE = 3'b000,
      CST_CONV = 3'b001,
      CST_SETTLE = 3'b010,
      CST_WAIT_SER = 3'b011,
      CST_BUSY_TAIL = 3'b100
   } acr_cst_t;

   typedef enum logic [1:0] {
      SST_IDLE = 2'b00,
      SST_LEAD = 2'b01,
      SST_SHIFT = 2'b10,
      SST_TAIL = 2'b11
   } acr_sst_t;

   typedef struct packed {
      acr_cst_t cst;
      acr_sst_t sst;
      logic [11:0] ccnt;
      logic [5:0] scnt;
      logic [4:0] bits;
      logic [RES_W-1:0] res;
      logic [RES_W-1:0] sh;
      logic busy;
      logic frame;
      logic cnv_prev;
      logic ext_prev;
      logic cs_prev;
      logic [RES_W-1:0] data;
      logic data_oe_n;
      logic sclk_oe_n;
      logic sync;
      logic sync_oe_n;
      logic sdo;
      logic sdo_oe_n;
   } acr_state_t;

   acr_state_t q;
   acr_state_t d;

   logic is_ser;
   logic is_master;
   logic is_after;
   logic [1:0] div_eff;
   logic [4:0] half_w;
   logic sclk_w;
   logic fall_w;
   logic start_w;
   logic ser_go;
   logic ser_done;
   logic [RES_W-1:0] ser_load;

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   // Divider is honoured only in master read-after-convert
   assign is_ser = serial_parallel_select_in;
   assign is_master = is_ser & ~clock_source_select_in;
   assign is_after = is_master & ~read_during_convert_select_in;
   assign div_eff = is_after ? clock_divide_select_in : DIV_NONE;
   assign half_w = sclk_half(div_eff);
   assign start_w = q.cnv_prev & ~convert_start_n_in;
   assign ser_done = (q.sst == SST_TAIL) && (q.scnt == tail_cyc(div_eff) - 6'h01);

   // ---------------------------------------------------------------
   // Internal serial clock
   // ---------------------------------------------------------------
   acr_sclk_div u_div (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .run_in(q.sst == SST_SHIFT),
      .half_in(half_w),
      .sclk_out(sclk_w),
      .fall_out(fall_w)
   );

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      ser_go = 1'b0;
      ser_load = q.res;
      d.cnv_prev = convert_start_n_in;
      d.ext_prev = ext_sclk_in;
      d.cs_prev = cs_n_in;

      // Conversion sequencer; starts during a conversion are ignored
      unique case (q.cst)
         CST_IDLE: begin
            if (start_w) begin
               d.cst = CST_CONV;
               d.busy = 1'b1;
               d.ccnt = 12'h000;
            end
         end
         CST_CONV: begin
            d.ccnt = q.ccnt + 12'h001;
            // Previous result goes out while converting
            if (is_master && read_during_convert_select_in && q.ccnt == 12'(SYNC_RDC_CYC - 1)) begin
               ser_go = 1'b1;
            end
            if (q.ccnt == 12'(CONV_CYC - 1)) begin
               d.res = conv_result_in;
               d.cst = CST_SETTLE;
               d.ccnt = 12'h000;
            end
         end
         CST_SETTLE: begin
            // Result held on the bus before busy drops
            d.ccnt = q.ccnt + 12'h001;
            if (q.ccnt == 12'(DATA_TO_BUSY_CYC - 1)) begin
               d.ccnt = 12'h000;
               if (is_after) begin
                  ser_go = 1'b1;
                  d.cst = CST_WAIT_SER;
               end else begin
                  d.busy = 1'b0;
                  d.cst = CST_IDLE;
               end
            end
         end
         CST_WAIT_SER: begin
            if (ser_done) begin
               d.cst = CST_BUSY_TAIL;
               d.ccnt = 12'h000;
            end
         end
         CST_BUSY_TAIL: begin
            d.ccnt = q.ccnt + 12'h001;
            if (q.ccnt == 12'(SYNC_TO_BUSY_CYC - 1)) begin
               d.busy = 1'b0;
               d.cst = CST_IDLE;
            end
         end
         default: begin
            d.cst = CST_IDLE;
            d.busy = 1'b0;
         end
      endcase

      // Master serial framer
      unique case (q.sst)
         SST_IDLE: begin
            if (ser_go && q.frame == 1'b0) begin
               d.sst = SST_LEAD;
               d.frame = 1'b1;
               d.sh = ser_load;
               d.scnt = 6'h00;
            end
         end
         SST_LEAD: begin
            d.scnt = q.scnt + 6'h01;
            if (q.scnt == lead_cyc(div_eff) - 6'h01) begin
               d.sst = SST_SHIFT;
               d.bits = 5'h00;
            end
         end
         SST_SHIFT: begin
            // Bit advances on the falling edge, host samples on the rise
            if (fall_w) begin
               d.sh = {q.sh[RES_W-2:0], 1'b0};
               d.bits = q.bits + 5'h01;
               if (q.bits == BIT_LAST) begin
                  d.sst = SST_TAIL;
                  d.scnt = 6'h00;
               end
            end
         end
         SST_TAIL: begin
            d.scnt = q.scnt + 6'h01;
            if (ser_done) begin
               d.frame = 1'b0;
               d.sst = SST_IDLE;
            end
         end
      endcase

      // Slave mode: load on select, shift on each external rising edge
      if (is_ser && clock_source_select_in) begin
         if (q.cs_prev && !cs_n_in) begin
            d.sh = q.res;
         end else if (!cs_n_in && !q.ext_prev && ext_sclk_in) begin
            d.sh = {q.sh[RES_W-2:0], 1'b0};
         end
      end

      // Pin drivers, all registered; enables are active low
      d.data = d.res;
      d.data_oe_n = ~(~is_ser & ~cs_n_in & ~rd_n_in);
      d.sclk_oe_n = ~(is_master & ~cs_n_in);
      d.sync_oe_n = ~(is_master & ~cs_n_in);
      d.sync = d.frame ^ frame_polarity_select_in;
      d.sdo = d.sh[RES_W-1];
      d.sdo_oe_n = ~(is_ser & ~cs_n_in);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         q <= '0;
         q.cnv_prev <= 1'b1;
         q.cs_prev <= 1'b1;
         q.data_oe_n <= 1'b1;
         q.sclk_oe_n <= 1'b1;
         q.sync_oe_n <= 1'b1;
         q.sdo_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign busy_out = q.busy;
   assign data_out = q.data;
   assign data_oe_n_out = q.data_oe_n;
   assign sclk_out = sclk_w;
   assign sclk_oe_n_out = q.sclk_oe_n;
   assign sync_out = q.sync;
   assign sync_oe_n_out = q.sync_oe_n;
   assign serial_data_out = q.sdo;
   assign serial_data_oe_n_out = q.sdo_oe_n;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   localparam int BUSY_MAX_CYC = 156;
   localparam int BUSY_AFTER_MAX_CYC = 718;
   localparam int RDC_LO = 64;
   localparam int RDC_HI = 68;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence s_start;
      q.cst == CST_IDLE && start_w;
   endsequence

   sequence s_frame_end;
      $fell(q.frame);
   endsequence

   a_busy_rise: assert property (s_start |=> busy_out)
      else $error("busy not raised after start");
   a_busy_width: assert property ($rose(busy_out) && !is_after |-> ##[1:BUSY_MAX_CYC] !busy_out)
      else $error("busy too long");
   a_busy_after: assert property ($rose(busy_out) && is_after |-> ##[1:BUSY_AFTER_MAX_CYC] !busy_out)
      else $error("busy too long after convert");
   a_data_ahead: assert property ($fell(busy_out) |-> data_out == $past(data_out, 2))
      else $error("data not settled before busy fell");
   a_bus_grant: assert property (!is_ser && !cs_n_in && !rd_n_in |=> !data_oe_n_out)
      else $error("bus not driven after request");
   a_rdc_sync: assert property ((s_start and (is_master && read_during_convert_select_in))
      |-> ##[RDC_LO:RDC_HI] $rose(q.frame))
      else $error("during-convert sync late");
   a_sync_busy: assert property (s_frame_end and is_after |-> busy_out ##[3:6] !busy_out)
      else $error("busy not released after sync");
   a_lead_quiet: assert property ($rose(q.frame) |-> !sclk_w ##1 !sclk_w)
      else $error("clock edge too soon after sync");
   a_tail_quiet: assert property (s_frame_end |-> !sclk_w && $past(!sclk_w))
      else $error("sync ended before clock settled");
   a_clk_float: assert property (cs_n_in |=> sclk_oe_n_out && sync_oe_n_out)
      else $error("clock or sync still driven");
   a_slave_shift: assert property (is_ser && clock_source_select_in && !cs_n_in && !q.cs_prev
      && !q.ext_prev && ext_sclk_in |=> serial_data_out == $past(q.sh[RES_W-2]))
      else $error("slave data not updated");
   a_sync_level: assert property (##1 (sync_out == ($past(q.frame) ^ $past(frame_polarity_select_in))
      || $changed(q.frame)))
      else $error("sync polarity wrong");
endmodule // acr_top

// ===== sim/acr_host_model.sv
// Host side model: captures serial words and makes the slave clock
`timescale 1ns/10ps
module acr_host_model (
   input wire logic clk_in,
   input wire logic clear_in,
   input wire logic slave_go_in,
   input wire logic sclk_in,
   input wire logic sclk_oe_n_in,
   input wire logic sdata_in,
   output logic ext_sclk_out,
   output logic [15:0] word_out,
   output logic [15:0] slave_word_out,
   output int bits_out,
   output int slave_bits_out,
   output int period_out
);
   logic sclk_q;
   int now_q = 0;
   int last_q = 0;

   // Master capture on each sampled rise of the driven device clock
   always @(posedge clk_in) begin
      now_q <= now_q + 1;
      sclk_q <= sclk_in;
      if (clear_in) begin
         bits_out <= 0;
      end else if (!sclk_oe_n_in && sclk_in && !sclk_q) begin
         word_out <= {word_out[14:0], sdata_in};
         bits_out <= bits_out + 1;
         period_out <= now_q - last_q;
         last_q <= now_q;
      end
   end

   // Slave clock, still between frames; data sampled as it rises
   initial begin
      ext_sclk_out = 1'b0;
      forever begin
         @(posedge clk_in);
         if (slave_go_in) begin
            slave_bits_out <= 0;
            repeat (16) begin
               repeat (4) @(posedge clk_in);
               ext_sclk_out <= 1'b1;
               slave_word_out <= {slave_word_out[14:0], sdata_in};
               slave_bits_out <= slave_bits_out + 1;
               repeat (4) @(posedge clk_in);
               ext_sclk_out <= 1'b0;
            end
         end
      end
   end
endmodule // acr_host_model

// ===== sim/tb.sv
// Self-checking bench for the conversion and readout block
`timescale 1ns/10ps
module tb;
   import acr_pkg::*;
   logic clk_in, reset_in, convert_start_n_in, cs_n_in, rd_n_in;
   logic sp_sel, src_sel, rdc_sel, pol_sel, clear, go, host_sclk, sclk_wire;
   logic busy_out, data_oe_n_out, sclk_out, sclk_oe_n_out, sync_out, sync_oe_n_out, sdo, sdo_oe_n;
   logic [1:0] div_sel;
   logic [RES_W-1:0] result, data_out, word, sword, prev;
   int n_mismatch = 0;
   int num_checks = 0;
   int bits, sbits, period, b_on, b_off, d_on, s_on, s_off, f_rise, l_hi;

   // Clock, and the shared serial clock wire
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   assign sclk_wire = (sclk_oe_n_out === 1'b0) ? sclk_out : host_sclk;

   acr_top u_acr_top (.clk_in(clk_in), .reset_in(reset_in), .convert_start_n_in(convert_start_n_in),
      .conv_result_in(result), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .serial_parallel_select_in(sp_sel),
      .clock_source_select_in(src_sel), .read_during_convert_select_in(rdc_sel),
      .frame_polarity_select_in(pol_sel), .clock_divide_select_in(div_sel), .ext_sclk_in(sclk_wire),
      .busy_out(busy_out), .data_out(data_out), .data_oe_n_out(data_oe_n_out), .sclk_out(sclk_out),
      .sclk_oe_n_out(sclk_oe_n_out), .sync_out(sync_out), .sync_oe_n_out(sync_oe_n_out),
      .serial_data_out(sdo), .serial_data_oe_n_out(sdo_oe_n));
   acr_host_model u_acr_host_model (.clk_in(clk_in), .clear_in(clear), .slave_go_in(go),
      .sclk_in(sclk_wire), .sclk_oe_n_in(sclk_oe_n_out), .sdata_in(sdo), .ext_sclk_out(host_sclk),
      .word_out(word), .slave_word_out(sword), .bits_out(bits), .slave_bits_out(sbits),
      .period_out(period));

   // --------
   // Compare and report
   // --------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic rng(input string what, input int lo, input int hi, input int got);
      num_checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One conversion; 1300 cycles keeps starts 10 us apart
   task automatic run_conv(input logic [15:0] res);
      @(posedge clk_in);
      convert_start_n_in <= 1'b0;
      result <= res;
      // Times count edges after the strobe edge; -1 means not yet seen
      b_on = -1;
      d_on = -1;
      s_on = -1;
      f_rise = -1;
      for (int t = 0; t < 1300; t++) begin
         @(posedge clk_in);
         if (t == 2) convert_start_n_in <= 1'b1; // Strobe held 3 cycles
         #1;
         if (busy_out === 1'b1 && b_on < 0) b_on = t;
         if (busy_out === 1'b1) b_off = t + 1;
         if (data_out === res && d_on < 0) d_on = t;
         if (sync_out === ~pol_sel && sync_oe_n_out === 1'b0) begin
            if (s_on < 0) s_on = t;
            s_off = t + 1;
         end
         if (sclk_out === 1'b1 && sclk_oe_n_out === 1'b0) begin
            if (f_rise < 0) f_rise = t;
            l_hi = t + 1;
         end
      end
   endtask

   // --------
   // Scenarios
   // --------
   task automatic test_parallel;
      sp_sel <= 1'b0;
      run_conv(16'ha5c3);
      rng("busy rise", 0, 3, b_on);
      rng("busy width", 1, 156, b_off - b_on);
      rng("data valid", 0, 155, d_on);
      rng("data lead", 2, 200, b_off - d_on);
      @(posedge clk_in);
      rd_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      chk("bus drive", 0, data_oe_n_out);
      chk("bus data", 16'ha5c3, data_out);
      @(posedge clk_in);
      rd_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      chk("bus release", 1, data_oe_n_out);
      $display("test parallel done");
   endtask

   // Master pins follow chip select; no parallel drive in serial mode
   task automatic test_deselect;
      @(posedge clk_in);
      sp_sel <= 1'b1;
      src_sel <= 1'b0;
      cs_n_in <= 1'b1;
      rd_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      chk("sclk float", 1, sclk_oe_n_out);
      chk("sync float", 1, sync_oe_n_out);
      chk("serial bus", 1, data_oe_n_out);
      chk("sdata float", 1, sdo_oe_n);
      @(posedge clk_in);
      cs_n_in <= 1'b0;
      rd_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1;
      chk("sclk drive", 0, sclk_oe_n_out);
      chk("sdata drive", 0, sdo_oe_n);
      $display("test deselect done");
   endtask

   // Every divider setting, polarity alternating
   task automatic test_after;
      int lo[4] = '{4, 7, 13, 25};
      int hi[4] = '{5, 8, 17, 35};
      int bmax[4] = '{250, 312, 437, 718};
      int tail[4] = '{1, 7, 17, 37};
      for (int d = 0; d < 4; d++) begin
         @(posedge clk_in);
         rdc_sel <= 1'b0;
         div_sel <= 2'(d);
         pol_sel <= d[0];
         clear <= 1'b1;
         @(posedge clk_in);
         clear <= 1'b0;
         prev = 16'h1234 + 16'(d) * 16'h1111;
         run_conv(prev);
         chk("word bits", 16, bits);
         chk("word", prev, word);
         rng("sclk period", lo[d], hi[d], period);
         rng("sync start", 150, 160, s_on);
         rng("busy after sync", 3, 5, b_off - s_off);
         rng("busy width", 1, bmax[d], b_off - b_on);
         rng("sync lead", (d == 0) ? 1 : 3, 40, f_rise - s_on);
         rng("sync tail", tail[d], 60, s_off - l_hi);
      end
      $display("test after convert done");
   endtask

   // Divider set but ignored; frame carries the previous result
   task automatic test_during;
      @(posedge clk_in);
      rdc_sel <= 1'b1;
      div_sel <= 2'h3;
      pol_sel <= 1'b1;
      clear <= 1'b1;
      @(posedge clk_in);
      clear <= 1'b0;
      run_conv(16'h5a0f);
      chk("rdc word", prev, word);
      rng("rdc sync", 64, 68, s_on);
      rng("rdc period", 4, 5, period);
      rng("rdc busy", 1, 156, b_off - b_on);
      chk("rdc bits", 16, bits);
      prev = 16'h5a0f;
      $display("test during convert done");
   endtask

   // Host clocks the word out; a hang ends the run
   task automatic test_slave;
      int n;
      @(posedge clk_in);
      src_sel <= 1'b1;
      cs_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      cs_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      n = 0;
      while (sbits != 16 && n < 400) begin
         @(posedge clk_in);
         n++;
      end
      chk("slave bits", 16, sbits);
      if (sbits != 16) end_of_test();
      chk("slave word", prev, sword);
      chk("slave clk idle", 1, sclk_oe_n_out);
      $display("test slave done");
   endtask

   // Main sequence
   initial begin
      reset_in = 1'b1;
      convert_start_n_in = 1'b1;
      cs_n_in = 1'b0;
      rd_n_in = 1'b1;
      sp_sel = 1'b0;
      src_sel = 1'b0;
      rdc_sel = 1'b0;
      pol_sel = 1'b0;
      div_sel = 2'h0;
      result = 16'h0000;
      clear = 1'b1;
      go = 1'b0;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      clear <= 1'b0;
      repeat (2) @(posedge clk_in);
      test_parallel();
      test_deselect();
      test_after();
      test_during();
      test_slave();
      end_of_test();
   end
endmodule // tb
